// ==== design/trb_consts.vh ====
// Purpose: Constants for the result readout bank
// Assumes: Included by trb_result_bank.v only
// Notes:   Addresses are register indices on the serial register port
`ifndef TRB_CONSTS_VH
`define TRB_CONSTS_VH
`define TRB_ADDR_W 6
`define TRB_WORD_W 24
`define TRB_ADDR_TALLY3 6'h15
`define TRB_ADDR_FINE4 6'h16
`define TRB_ADDR_TALLY4 6'h17
`define TRB_ADDR_FINE5 6'h18
`define TRB_ADDR_TALLY5 6'h19
`define TRB_ADDR_FINE6 6'h1A
`define TRB_PAR_BIT 23
`define TRB_TALLY_W 16
`define TRB_FINE_W 23
`define TRB_PAD_W 7
`define TRB_RESET_WORD 24'h000000
`endif

// ==== design/trb_result_bank.v ====
// Purpose: Read-only result registers of one converter channel
// Assumes: Measurement engine drives results and a one-cycle load strobe
// Notes:   Read data is registered; one cycle from request to valid
//          A deselected request is dropped; word and hit flag hold, valid stays low
//          A load and a read on one edge return the word before the load
//          Unmapped indices answer zero with the hit flag low
//
// Behaviour
// RULE_01: Coarse tally shows 16-bit cycle count in 15:0, parity in 23.
// RULE_02: Coarse tally bits 22:16 read zero, kept for averaging mode.
// RULE_03: Fine result is 23-bit unsigned in 22:0, parity in bit 23.
// RULE_04: Fine results four, five, six sit at 16h, 18h, 1Ah.
// RULE_05: Coarse tallies three, four, five sit at 15h, 17h, 19h.
// RULE_06: All registers read-only; reset clears every bit including parity.
// RULE_07: Host asserts this channel's chip select during the access.
// RULE_08: Parity bit makes the whole 24-bit word even parity.
`timescale 1ns/1ps
`default_nettype none
`include "trb_consts.vh"

module trb_result_bank
(
    input wire core_clk_i,                          // 10 MHz core clock
    input wire rst_n_i,                             // Sync reset, active low
    input wire channel_chip_select_n_i,             // Channel select, low
    input wire rd_req_i,                            // Read request pulse
    input wire [`TRB_ADDR_W-1:0] rd_addr_i,         // Register index
    output reg [`TRB_WORD_W-1:0] rd_data_o,         // Read word
    output reg rd_valid_o,                          // Read data valid pulse
    output reg rd_hit_o,                            // Address was mapped
    input wire load_i,                              // Result load strobe
    input wire [`TRB_TALLY_W-1:0] coarse_tally_three_i, // Stop 3 tally
    input wire [`TRB_TALLY_W-1:0] coarse_tally_four_i,  // Stop 4 tally
    input wire [`TRB_TALLY_W-1:0] coarse_tally_five_i,  // Stop 5 tally
    input wire [`TRB_FINE_W-1:0] fine_result_four_i,    // Fine interval 4
    input wire [`TRB_FINE_W-1:0] fine_result_five_i,    // Fine interval 5
    input wire [`TRB_FINE_W-1:0] fine_result_six_i      // Fine interval 6
);

    // Stored result words, each with parity on top
    reg [`TRB_WORD_W-1:0] coarse_tally_stop3;
    reg [`TRB_WORD_W-1:0] coarse_tally_stop4;
    reg [`TRB_WORD_W-1:0] coarse_tally_stop5;
    reg [`TRB_WORD_W-1:0] fine_interval_four;
    reg [`TRB_WORD_W-1:0] fine_interval_five;
    reg [`TRB_WORD_W-1:0] fine_interval_six;
    // Packed words waiting for the next load strobe
    wire [`TRB_WORD_W-1:0] next_tally3;
    wire [`TRB_WORD_W-1:0] next_tally4;
    wire [`TRB_WORD_W-1:0] next_tally5;
    wire [`TRB_WORD_W-1:0] next_fine4;
    wire [`TRB_WORD_W-1:0] next_fine5;
    wire [`TRB_WORD_W-1:0] next_fine6;
    // Read path
    reg [`TRB_WORD_W-1:0] next_rd_data;
    reg next_rd_hit;
    wire rd_take;

    // Packs a tally with zero padding and even parity
    function [`TRB_WORD_W-1:0] trb_pack_tally;
        input [`TRB_TALLY_W-1:0] cnt;
        begin
            trb_pack_tally = {^cnt, {`TRB_PAD_W{1'b0}}, cnt}; // [RULE_01] [RULE_02] [RULE_08]
        end
    endfunction

    // Packs a fine result with even parity on top
    function [`TRB_WORD_W-1:0] trb_pack_fine;
        input [`TRB_FINE_W-1:0] val;
        begin
            trb_pack_fine = {^val, val}; // [RULE_03] [RULE_08]
        end
    endfunction

    // Pack every incoming result into its register layout
    assign next_tally3 = trb_pack_tally(coarse_tally_three_i); // [RULE_01]
    assign next_tally4 = trb_pack_tally(coarse_tally_four_i); // [RULE_01]
    assign next_tally5 = trb_pack_tally(coarse_tally_five_i); // [RULE_01]
    assign next_fine4 = trb_pack_fine(fine_result_four_i); // [RULE_03]
    assign next_fine5 = trb_pack_fine(fine_result_five_i); // [RULE_03]
    assign next_fine6 = trb_pack_fine(fine_result_six_i); // [RULE_03]

    // Stop 3 tally; no write path from the host exists
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            coarse_tally_stop3 <= `TRB_RESET_WORD; // [RULE_06]
        end
        else if (load_i)
        begin
            coarse_tally_stop3 <= next_tally3;
        end
    end

    // Stop 4 tally, refreshed by each load
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            coarse_tally_stop4 <= `TRB_RESET_WORD; // [RULE_06]
        end
        else if (load_i)
        begin
            coarse_tally_stop4 <= next_tally4;
        end
    end

    // Stop 5 tally, refreshed by each load
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            coarse_tally_stop5 <= `TRB_RESET_WORD; // [RULE_06]
        end
        else if (load_i)
        begin
            coarse_tally_stop5 <= next_tally5;
        end
    end

    // Fourth fine result, refreshed by each load
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            fine_interval_four <= `TRB_RESET_WORD; // [RULE_06]
        end
        else if (load_i)
        begin
            fine_interval_four <= next_fine4;
        end
    end

    // Fifth fine result, refreshed by each load
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            fine_interval_five <= `TRB_RESET_WORD; // [RULE_06]
        end
        else if (load_i)
        begin
            fine_interval_five <= next_fine5;
        end
    end

    // Sixth fine result, refreshed by each load
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            fine_interval_six <= `TRB_RESET_WORD; // [RULE_06]
        end
        else if (load_i)
        begin
            fine_interval_six <= next_fine6;
        end
    end

    // Reads count only while this channel is selected
    assign rd_take = rd_req_i & ~channel_chip_select_n_i; // [RULE_07]

    // Address decode; unmapped indices read zero
    always @*
    begin
        next_rd_data = `TRB_RESET_WORD;
        next_rd_hit = 1'h1;
        if (rd_addr_i == `TRB_ADDR_TALLY3)
        begin
            next_rd_data = coarse_tally_stop3; // [RULE_05]
        end
        else if (rd_addr_i == `TRB_ADDR_FINE4)
        begin
            next_rd_data = fine_interval_four; // [RULE_04]
        end
        else if (rd_addr_i == `TRB_ADDR_TALLY4)
        begin
            next_rd_data = coarse_tally_stop4; // [RULE_05]
        end
        else if (rd_addr_i == `TRB_ADDR_FINE5)
        begin
            next_rd_data = fine_interval_five; // [RULE_04]
        end
        else if (rd_addr_i == `TRB_ADDR_TALLY5)
        begin
            next_rd_data = coarse_tally_stop5; // [RULE_05]
        end
        else if (rd_addr_i == `TRB_ADDR_FINE6)
        begin
            next_rd_data = fine_interval_six; // [RULE_04]
        end
        else
        begin
            next_rd_hit = 1'h0;
        end
    end

    // Valid pulse one cycle after a taken request
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_valid_o <= 1'h0;
        end
        else
        begin
            rd_valid_o <= rd_take;
        end
    end

    // Read word holds until the next taken request
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_o <= `TRB_RESET_WORD; // [RULE_06]
        end
        else if (rd_take)
        begin
            rd_data_o <= next_rd_data;
        end
    end

    // Hit flag holds until the next taken request
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_hit_o <= 1'h0;
        end
        else if (rd_take)
        begin
            rd_hit_o <= next_rd_hit;
        end
    end

endmodule // trb_result_bank
`default_nettype wire

// ==== bench/trb_result_bank_props.sv ====
// Purpose: Port checks on the result bank
// Assumes: One clock, reset synchronous and active low
// Notes:   Bound to the bank; sees only its read-side ports
`timescale 1ns/1ps
`default_nettype none
module trb_result_bank_props (
    input wire logic core_clk_i, rst_n_i, channel_chip_select_n_i, rd_req_i,
    input wire logic [5:0] rd_addr_i,
    input wire logic [23:0] rd_data_o,
    input wire logic rd_valid_o, rd_hit_o
);
    // Taken read and mapped index
    wire tk = rd_req_i && !channel_chip_select_n_i;
    wire mp = rd_addr_i >= 6'h15 && rd_addr_i <= 6'h1A;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_vld; tk |=> rd_valid_o; endproperty
    a_vld: assert property (p_vld) else $error("no valid");
    property p_one; rd_valid_o |-> $past(tk); endproperty
    a_one: assert property (p_one) else $error("stray valid");
    property p_par; rd_valid_o |-> !(^rd_data_o); endproperty
    a_par: assert property (p_par) else $error("parity");
    property p_pad; rd_valid_o && $past(rd_addr_i[0]) |-> !rd_data_o[22:16];
    endproperty
    a_pad: assert property (p_pad) else $error("pad");
    property p_hit; rd_valid_o |-> rd_hit_o == $past(mp); endproperty
    a_hit: assert property (p_hit) else $error("hit");
    property p_mis; rd_valid_o && !rd_hit_o |-> rd_data_o == 24'h000000;
    endproperty
    a_mis: assert property (p_mis) else $error("miss");
    property p_hld; !rd_valid_o |-> $stable(rd_data_o); endproperty
    a_hld: assert property (p_hld) else $error("hold");
    property p_clr; $rose(rst_n_i) |-> !rd_data_o && !rd_hit_o; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_cs; channel_chip_select_n_i |=> $stable(rd_hit_o); endproperty
    a_cs: assert property (p_cs) else $error("select");
    cover property (rd_valid_o && rd_hit_o);
    cover property (rd_valid_o && !rd_hit_o);
    cover property (rd_req_i && channel_chip_select_n_i);
    cover property ($rose(rst_n_i));
endmodule // trb_result_bank_props
bind trb_result_bank trb_result_bank_props trb_result_bank_props_inst (
    .core_clk_i, .rst_n_i, .channel_chip_select_n_i, .rd_req_i, .rd_addr_i,
    .rd_data_o, .rd_valid_o, .rd_hit_o);
`default_nettype wire

// ==== bench/trb_host.sv ====
// Purpose: Host model reading the result bank
// Assumes: One clock shared with the bank
// Notes:   Address is scrambled while idle to expose late sampling
`timescale 1ns/1ps
`default_nettype none
module trb_host (
    input wire logic clk, // Bank clock
    output var logic cs_n = 1'b1, // Channel select, low
    output var logic req = 1'b0, // Read request
    output var logic [5:0] ad = 6'h00 // Register index
);
    // One read: request for one edge, then release
    task automatic rd(input logic [5:0] a, input logic s);
        @(posedge clk);
        cs_n <= s;
        req <= 1'b1;
        ad <= a;
        @(posedge clk);
        cs_n <= 1'b1;
        req <= 1'b0;
        ad <= ~a;
    endtask
endmodule // trb_host
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: Bench for the result bank
// Assumes: Host model drives the read port
// Notes:   Each scenario task judges its own reads
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst_n = 1'b0, ld = 1'b0, v, h, cs, rq;
    logic [15:0] c3 = 16'h0000, c4 = 16'h0000, c5 = 16'h0000;
    logic [22:0] f4 = 23'h000000, f5 = 23'h000000, f6 = 23'h000000;
    logic [5:0] ad;
    logic [23:0] d;
    int err_total = 0, num_checks = 0;
    always #50 clk = ~clk;
    trb_host trb_host_inst (.clk, .cs_n(cs), .req(rq), .ad);
    trb_result_bank trb_result_bank_inst (.core_clk_i(clk), .rst_n_i(rst_n),
        .channel_chip_select_n_i(cs), .rd_req_i(rq), .rd_addr_i(ad),
        .rd_data_o(d), .rd_valid_o(v), .rd_hit_o(h), .load_i(ld),
        .coarse_tally_three_i(c3), .coarse_tally_four_i(c4),
        .coarse_tally_five_i(c5), .fine_result_four_i(f4),
        .fine_result_five_i(f5), .fine_result_six_i(f6));
    // Word with even parity on top
    function logic [23:0] pw(input logic [22:0] x);
        return {^x, x};
    endfunction
    task chk(input logic [25:0] s, e, input string n);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    task complete_run;
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One read, then valid, hit and word compared
    task rdc(input logic [5:0] a, input logic s, input logic [25:0] e);
        trb_host_inst.rd(a, s);
        #1 chk({v, h, d}, e, "valid_hit_word");
    endtask
    task t_rst;
        for (int a = 6'h15; a <= 6'h1A; a++)
            rdc(a[5:0], 1'b0, 26'h3000000);
    endtask
    // Load parity corner values, read every place
    task t_load;
        @(posedge clk);
        {c3, c4, c5, f4, f5, f6} <= {16'hFFFF, 16'h0001, 16'h8000,
            23'h7FFFFF, 23'h400000, 23'h000003};
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        rdc(6'h15, 1'b0, {2'b11, pw({7'h00, c3})});
        rdc(6'h16, 1'b0, {2'b11, pw(f4)});
        rdc(6'h17, 1'b0, {2'b11, pw({7'h00, c4})});
        rdc(6'h18, 1'b0, {2'b11, pw(f5)});
        rdc(6'h19, 1'b0, {2'b11, pw({7'h00, c5})});
        rdc(6'h1A, 1'b0, {2'b11, pw(f6)});
    endtask
    // Deselected read ignored, then unmapped places
    task t_ref;
        rdc(6'h16, 1'b1, {2'b01, pw(f6)});
        rdc(6'h1B, 1'b0, 26'h2000000);
        rdc(6'h14, 1'b0, 26'h2000000);
    endtask
    // Load and read on one edge: the read returns the old word
    task t_same_edge;
        logic [25:0] e_old;
        e_old = {2'b11, pw(f4)};
        fork
            trb_host_inst.rd(6'h16, 1'b0);
            begin
                @(posedge clk);
                f4 <= 23'h000001;
                ld <= 1'b1;
                @(posedge clk);
                ld <= 1'b0;
            end
        join
        #1 chk({v, h, d}, e_old, "same_edge_old");
        rdc(6'h16, 1'b0, {2'b11, pw(f4)});
    endtask
    // Mid-run reset wipes loaded results and the read outputs
    task t_mid_rst;
        rdc(6'h15, 1'b0, {2'b11, pw({7'h00, c3})});
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({v, h, d}, 26'h0000000, "after_reset");
        for (int a = 6'h15; a <= 6'h1A; a++)
            rdc(a[5:0], 1'b0, 26'h3000000);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_rst;
        t_load;
        t_ref;
        t_same_edge;
        t_mid_rst;
        complete_run;
    end
endmodule // tb
`default_nettype wire
